// ---- src/gauge_cfg.svh ----
// Offsets, field positions, reset values and bus constants of the gauge register bank
`ifndef GAUGE_CFG_SVH
`define GAUGE_CFG_SVH

// ---------------------------------------------------------------
// Register offsets (8-bit pointer values)
// ---------------------------------------------------------------
`define OFS_NOMINAL_CELL_CAPACITY     8'h18
`define OFS_EMPTY_RECOVERY_THRESHOLDS 8'h3a

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_NOMINAL_CELL_CAPACITY     16'h0bb8
`define RST_EMPTY_RECOVERY_THRESHOLDS 16'ha561

// ---------------------------------------------------------------
// Threshold register fields
// ---------------------------------------------------------------
`define EMPTY_FIELD_MSB    15
`define EMPTY_FIELD_LSB    7
`define RECOVERY_FIELD_MSB 6
`define RECOVERY_FIELD_LSB 0

// 10 mV / 78.125 uV = 128, 40 mV / 78.125 uV = 512
`define EMPTY_STEP_SHIFT    7
`define RECOVERY_STEP_SHIFT 9

// ---------------------------------------------------------------
// Two-wire link
// ---------------------------------------------------------------
`define DEFAULT_TARGET_ADDR 7'h2a
`define READ_UNMAPPED       16'h0000

`endif

// ---- src/gauge_pkg.sv ----
// Types shared by the gauge register bank and its two-wire target
package gauge_pkg;

   // ---------------------------------------------------------------
   // Fixed-point register encodings
   // ---------------------------------------------------------------
   typedef logic [15:0]        capacity_t;     // 0.5 mAh per step
   typedef logic [15:0]        percent_t;      // 1/256 % per step
   typedef logic [15:0]        voltage_t;      // 78.125 uV per step
   typedef logic signed [15:0] current_t;      // 156.25 uA per step
   typedef logic signed [15:0] temperature_t;  // 1/256 degC per step
   typedef logic [15:0]        resistance_t;   // 1/4096 ohm per step
   typedef logic [15:0]        time_t;         // 5.625 s per step

   // ---------------------------------------------------------------
   // Register request from the link
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic [7:0]  ptr;
      logic [15:0] wdata;
   } reg_req_s;

   typedef enum logic [3:0] {
      LINK_IDLE,
      LINK_ADDR,
      LINK_ACK_ADDR,
      LINK_PTR,
      LINK_ACK_PTR,
      LINK_WDATA,
      LINK_ACK_WDATA,
      LINK_RDATA,
      LINK_HOST_ACK
   } link_state_e;

   typedef struct packed {
      link_state_e st;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic [7:0]  tx;
      logic        rw;
      logic        hi;
      logic [7:0]  wlo;
      logic        sda_oe;
      logic        scl_q;
      logic        sda_q;
      reg_req_s    req;
   } link_st_s;

   typedef struct packed {
      capacity_t nominal;
      logic [15:0] thresholds;
      logic        empty;
      percent_t    rep_pct;
      capacity_t   rep_cap;
   } bank_st_s;

endpackage : gauge_pkg

// ---- src/twowire_target.sv ----
// Two-wire bus target: pointer byte, then 16-bit words low byte first; a read sends 0x00 as the low byte of every word after the first
`include "gauge_cfg.svh"

module twowire_target #(
   parameter logic [6:0] TARGET_ADDR = `DEFAULT_TARGET_ADDR
) (
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_oe,
   output gauge_pkg::reg_req_s    req,
   input  wire logic [15:0]       rdata
);

   gauge_pkg::link_st_s s;
   gauge_pkg::link_st_s next_s;

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (TARGET_ADDR < 7'h08 || TARGET_ADDR > 7'h77)
   begin : g_bad_addr
      $error("Target address lies in a reserved range");
   end

   assign scl_rise   = scl_i & ~s.scl_q;
   assign scl_fall   = ~scl_i & s.scl_q;
   assign start_seen = scl_i & s.scl_q & s.sda_q & ~sda_i;
   assign stop_seen  = scl_i & s.scl_q & ~s.sda_q & sda_i;

   // ---------------------------------------------------------------
   // Bit engine
   // ---------------------------------------------------------------
   always_comb
   begin
      next_s        = s;
      next_s.scl_q  = scl_i;
      next_s.sda_q  = sda_i;
      next_s.req.wr = 1'b0;
      // Pointer steps only after the write pulse has used it
      if (s.req.wr)
         next_s.req.ptr = s.req.ptr + 8'h01;
      if (start_seen)                                              // [RULE1]
      begin
         next_s.st     = gauge_pkg::LINK_ADDR;
         next_s.bitcnt = 4'h0;
         next_s.hi     = 1'b0;
         next_s.sda_oe = 1'b0;
      end
      else if (stop_seen)
      begin
         next_s.st     = gauge_pkg::LINK_IDLE;
         next_s.sda_oe = 1'b0;
      end
      else if (scl_rise && s.st != gauge_pkg::LINK_IDLE)
      begin
         next_s.shreg  = {s.shreg[6:0], sda_i};
         next_s.bitcnt = s.bitcnt + 4'h1;
      end
      else if (scl_fall)
      begin
         case (s.st)
            gauge_pkg::LINK_ADDR:
               if (s.bitcnt == 4'h8)
               begin
                  if (s.shreg[7:1] == TARGET_ADDR)
                  begin
                     next_s.sda_oe = 1'b1;
                     next_s.rw     = s.shreg[0];
                     next_s.st     = gauge_pkg::LINK_ACK_ADDR;
                  end
                  else
                     next_s.st = gauge_pkg::LINK_IDLE;
               end
            gauge_pkg::LINK_ACK_ADDR:
            begin
               next_s.bitcnt = 4'h0;
               next_s.hi     = 1'b0;
               if (s.rw)
               begin
                  next_s.tx     = rdata[7:0];
                  next_s.sda_oe = ~rdata[7];
                  next_s.st     = gauge_pkg::LINK_RDATA;
               end
               else
               begin
                  next_s.sda_oe = 1'b0;
                  next_s.st     = gauge_pkg::LINK_PTR;
               end
            end
            gauge_pkg::LINK_PTR:
               if (s.bitcnt == 4'h8)
               begin
                  next_s.req.ptr = s.shreg;
                  next_s.sda_oe  = 1'b1;
                  next_s.st      = gauge_pkg::LINK_ACK_PTR;
               end
            gauge_pkg::LINK_ACK_PTR,
            gauge_pkg::LINK_ACK_WDATA:
            begin
               next_s.sda_oe = 1'b0;
               next_s.bitcnt = 4'h0;
               next_s.st     = gauge_pkg::LINK_WDATA;
            end
            gauge_pkg::LINK_WDATA:
               if (s.bitcnt == 4'h8)
               begin
                  next_s.sda_oe = 1'b1;
                  next_s.st     = gauge_pkg::LINK_ACK_WDATA;
                  next_s.hi     = ~s.hi;
                  if (s.hi)
                  begin
                     next_s.req.wr    = 1'b1;
                     next_s.req.wdata = {s.shreg, s.wlo};
                  end
                  else
                     next_s.wlo = s.shreg;
               end
            gauge_pkg::LINK_RDATA:
               if (s.bitcnt == 4'h8)
               begin
                  next_s.sda_oe = 1'b0;
                  next_s.st     = gauge_pkg::LINK_HOST_ACK;
               end
               else
                  next_s.sda_oe = ~s.tx[3'(4'h7 - s.bitcnt)];
            gauge_pkg::LINK_HOST_ACK:
            begin
               next_s.bitcnt = 4'h0;
               // Host NACK ends the read; the word already sent stays coherent
               if (s.shreg[0])
               begin
                  next_s.sda_oe = 1'b0;
                  next_s.st     = gauge_pkg::LINK_IDLE;
               end
               else
               begin
                  next_s.hi = ~s.hi;
                  if (s.hi)
                  begin
                     next_s.req.ptr = s.req.ptr + 8'h01;
                     next_s.tx      = 8'h00;
                     next_s.sda_oe  = 1'b1;
                  end
                  else
                  begin
                     next_s.tx     = rdata[15:8];
                     next_s.sda_oe = ~rdata[15];
                  end
                  next_s.st = gauge_pkg::LINK_RDATA;
               end
            end
            default:
               next_s.sda_oe = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s       <= '0;
         s.st    <= gauge_pkg::LINK_IDLE;
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign sda_oe = s.sda_oe;
   assign req    = s.req;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_stop_release: assert property (@(posedge clock) disable iff (srst)   // [RULE1]
      stop_seen |=> !sda_oe)
      else $error("Target still drives data line after stop");

endmodule : twowire_target

// ---- src/gauge_register_bank.sv ----
// Gauge register bank: capacity and empty/recovery thresholds, empty detection
//
// Function
// RULE1 - Host reaches every register only through the two-wire bus.
// RULE2 - Capacity 0.5 mAh, time 5.625 s, resistance 1/4096 ohm, all unsigned.
// RULE3 - Percentage unsigned at 1/256 %; upper byte gives whole percent.
// RULE4 - Current and temperature signed; 156.25 uA and 1/256 degC steps.
// RULE5 - Nominal capacity register holds rated capacity, resets to 0x0BB8.
// RULE6 - Empty target field counts 10 mV steps, 0 to 5.11 V.
// RULE7 - Empty target field resets to the 3.3 V code.
// RULE8 - Report relative to empty target; zero percent once voltage reaches it.
// RULE9 - Recovery field counts 40 mV steps, 0 to 5.08 V.
// RULE10 - Recovery field resets to the 3.88 V code.
// RULE11 - Empty clears when voltage rises above recovery; detection then re-arms.
// RULE12 - Empty field bits 15..7, recovery field bits 6..0.
// RULE13 - Voltages unsigned at 78.125 uV; every register sixteen bits wide.
`include "gauge_cfg.svh"

module gauge_register_bank #(
   parameter logic [6:0] TARGET_ADDR = `DEFAULT_TARGET_ADDR
) (
   input  wire logic                    clock,
   input  wire logic                    srst,
   input  wire logic                    scl_i,
   input  wire logic                    sda_i,
   output logic                         sda_o,
   output logic                         sda_oe,
   input  wire gauge_pkg::voltage_t     cell_voltage,
   input  wire gauge_pkg::percent_t     raw_percent,
   input  wire gauge_pkg::capacity_t    raw_capacity,
   input  wire gauge_pkg::temperature_t temperature,
   output gauge_pkg::capacity_t         nominal_capacity,
   output logic                         empty_detected,
   output gauge_pkg::percent_t          reported_percent,
   output gauge_pkg::capacity_t         reported_capacity,
   output logic [7:0]                   whole_percent,
   output logic signed [7:0]            whole_degrees
);

   gauge_pkg::bank_st_s s;
   gauge_pkg::bank_st_s next_s;
   gauge_pkg::reg_req_s req;
   logic [15:0]         rdata;
   gauge_pkg::voltage_t empty_level;
   gauge_pkg::voltage_t recovery_level;

   // ---------------------------------------------------------------
   // Field decode
   // ---------------------------------------------------------------
   function automatic gauge_pkg::voltage_t empty_volts(input logic [15:0] thr);
      empty_volts = {thr[`EMPTY_FIELD_MSB:`EMPTY_FIELD_LSB],                // [RULE6]
                     {`EMPTY_STEP_SHIFT{1'b0}}};                             // [RULE12]
   endfunction : empty_volts

   function automatic gauge_pkg::voltage_t recovery_volts(input logic [15:0] thr);
      recovery_volts = {thr[`RECOVERY_FIELD_MSB:`RECOVERY_FIELD_LSB],        // [RULE9]
                        {`RECOVERY_STEP_SHIFT{1'b0}}};                       // [RULE12]
   endfunction : recovery_volts

   function automatic logic [15:0] read_word(input logic [7:0] ptr,
                                             input gauge_pkg::bank_st_s st);
      if (ptr == `OFS_NOMINAL_CELL_CAPACITY)
         read_word = st.nominal;
      else if (ptr == `OFS_EMPTY_RECOVERY_THRESHOLDS)
         read_word = st.thresholds;
      else
         read_word = `READ_UNMAPPED;
   endfunction : read_word

   assign empty_level    = empty_volts(s.thresholds);                      // [RULE13]
   assign recovery_level = recovery_volts(s.thresholds);

   // ---------------------------------------------------------------
   // Link
   // ---------------------------------------------------------------
   twowire_target #(
      .TARGET_ADDR (TARGET_ADDR)
   ) u_link (
      .clock  (clock),
      .srst   (srst),
      .scl_i  (scl_i),
      .sda_i  (sda_i),
      .sda_oe (sda_oe),
      .req    (req),
      .rdata  (rdata)
   );

   assign sda_o = 1'b0;
   assign rdata = read_word(req.ptr, s);                                    // [RULE1]

   // ---------------------------------------------------------------
   // Registers and empty detection
   // ---------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      if (req.wr)
      begin
         if (req.ptr == `OFS_NOMINAL_CELL_CAPACITY)                         // [RULE5]
            next_s.nominal = req.wdata;
         else if (req.ptr == `OFS_EMPTY_RECOVERY_THRESHOLDS)
            next_s.thresholds = req.wdata;
      end
      // Comparator uses the registered fields so a rewrite acts one cycle later
      if (!s.empty && cell_voltage <= empty_level)                           // [RULE8]
         next_s.empty = 1'b1;
      else if (s.empty && cell_voltage > recovery_level)                     // [RULE11]
         next_s.empty = 1'b0;
      next_s.rep_pct = next_s.empty ? 16'h0000 : raw_percent;               // [RULE8]
      next_s.rep_cap = next_s.empty ? 16'h0000 : raw_capacity;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s            <= '0;
         s.nominal    <= `RST_NOMINAL_CELL_CAPACITY;                        // [RULE5]
         s.thresholds <= `RST_EMPTY_RECOVERY_THRESHOLDS;                    // [RULE7] [RULE10]
      end
      else
         s <= next_s;
   end

   assign nominal_capacity  = s.nominal;                                    // [RULE2]
   assign empty_detected    = s.empty;
   assign reported_percent  = s.rep_pct;
   assign reported_capacity = s.rep_cap;
   assign whole_percent     = s.rep_pct[15:8];                              // [RULE3]
   assign whole_degrees     = temperature[15:8];                            // [RULE4]

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   sequence cap_write_seq;
      req.wr && req.ptr == `OFS_NOMINAL_CELL_CAPACITY;
   endsequence

   a_cap_reset_value: assert property ($fell(srst) |->                      // [RULE5]
      s.nominal == 16'h0bb8 || $past(req.wr))
      else $error("Nominal capacity reset value wrong");
   a_empty_reset_code: assert property ($fell(srst) |->                     // [RULE7]
      empty_level == 16'd42240 || $past(req.wr))
      else $error("Empty target reset code is not 3.3 V");
   a_recov_reset_code: assert property ($fell(srst) |->                     // [RULE10]
      recovery_level == 16'd49664 || $past(req.wr))
      else $error("Recovery reset code is not 3.88 V");
   a_cap_write_lands: assert property (cap_write_seq |=>                    // [RULE5]
      nominal_capacity == $past(req.wdata))
      else $error("Capacity write not stored");
   a_empty_set_cause: assert property ($rose(empty_detected) |->            // [RULE6]
      $past(cell_voltage) <= {$past(s.thresholds[15:7]), 7'h00})
      else $error("Empty raised above the target");
   a_empty_clear_cause: assert property ($fell(empty_detected) |->          // [RULE9]
      $past(cell_voltage) > {$past(s.thresholds[6:0]), 9'h000})
      else $error("Empty cleared at or below recovery");
   a_empty_rearm: assert property (!empty_detected && cell_voltage <= empty_level
      |=> empty_detected)                                                    // [RULE11]
      else $error("Empty detection did not fire when armed");
   a_zero_percent: assert property (empty_detected |->                      // [RULE8]
      reported_percent == 16'h0000 && whole_percent == 8'h00)
      else $error("Percentage not zero while empty");
   a_pct_follows_raw: assert property (!empty_detected && !$past(srst) |->  // [RULE3]
      reported_percent == $past(raw_percent))
      else $error("Percentage does not follow source");

endmodule : gauge_register_bank

// ---- testbench/host_twowire_model.sv ----
// Behavioural two-wire host that drives the gauge register bank
module host_twowire_model (
   input  wire logic clock,
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda_line
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Bus phases
   // ---------------------------------------------------------------
   // Phases of four clocks keep well above the three-clock minimum
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clock);
   endtask : hold

   // Also serves as repeated start: data released while clock is low
   task automatic start();
      sda_low = 1'b0;
      hold(2);
      scl = 1'b1;
      hold(4);
      sda_low = 1'b1;
      hold(4);
      scl = 1'b0;
      hold(2);
   endtask : start

   task automatic stop();
      sda_low = 1'b1;
      hold(2);
      scl = 1'b1;
      hold(4);
      sda_low = 1'b0;
      hold(4);
   endtask : stop

   // Data changes only mid-low, sampled at the end of the high phase
   task automatic bit_io(input logic b, output logic got);
      sda_low = ~b;
      hold(2);
      scl = 1'b1;
      hold(4);
      got = sda_line;
      scl = 1'b0;
      hold(2);
   endtask : bit_io

   // Eight data bits MSB first, then the acknowledge bit
   task automatic byte_io(input logic [7:0] tx, input logic ninth,
                          output logic [7:0] rx, output logic ninth_seen);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(ninth, ninth_seen);
   endtask : byte_io
endmodule : host_twowire_model

// ---- testbench/gauge_register_bank_tb_top.sv ----
// Self-checking bench for the gauge register bank
module gauge_register_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [6:0] ADDR  = 7'h2a;
   localparam int         LIMIT = 60000;

   logic                     clock;
   logic                     srst;
   logic                     scl;
   logic                     sda_low;
   wire logic                sda_line;
   logic                     sda_drv;
   logic                     sda_oe;
   gauge_pkg::voltage_t      cell_voltage;
   gauge_pkg::percent_t      raw_percent;
   gauge_pkg::capacity_t     raw_capacity;
   gauge_pkg::temperature_t  temperature;
   gauge_pkg::capacity_t     nominal_capacity;
   logic                     empty_detected;
   gauge_pkg::percent_t      reported_percent;
   gauge_pkg::capacity_t     reported_capacity;
   logic [7:0]               whole_percent;
   logic signed [7:0]        whole_degrees;
   int                       err_total;
   int                       checked;
   int                       cycles;

   // Open-drain wire with pull-up
   assign sda_line = ~(sda_low | sda_oe);

   gauge_register_bank #(.TARGET_ADDR(ADDR)) u_dut (
      .clock             (clock),
      .srst              (srst),
      .scl_i             (scl),
      .sda_i             (sda_line),
      .sda_o             (sda_drv),
      .sda_oe            (sda_oe),
      .cell_voltage      (cell_voltage),
      .raw_percent       (raw_percent),
      .raw_capacity      (raw_capacity),
      .temperature       (temperature),
      .nominal_capacity  (nominal_capacity),
      .empty_detected    (empty_detected),
      .reported_percent  (reported_percent),
      .reported_capacity (reported_capacity),
      .whole_percent     (whole_percent),
      .whole_degrees     (whole_degrees)
   );

   host_twowire_model u_host (
      .clock    (clock),
      .scl      (scl),
      .sda_low  (sda_low),
      .sda_line (sda_line)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic report_and_stop();
      if (err_total == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk

   task automatic wr_word(input logic [7:0] p, input logic [15:0] d);
      logic [7:0] rx;
      logic       n;
      logic       ok;
      ok = 1'b1;
      u_host.start();
      u_host.byte_io({ADDR, 1'b0}, 1'b1, rx, n);
      ok &= ~n;
      u_host.byte_io(p, 1'b1, rx, n);
      ok &= ~n;
      u_host.byte_io(d[7:0], 1'b1, rx, n);
      ok &= ~n;
      u_host.byte_io(d[15:8], 1'b1, rx, n);
      ok &= ~n;
      u_host.stop();
      chk("write ack", 16'h0001, {15'h0000, ok});
   endtask : wr_word

   task automatic rd_word(input logic [7:0] p, output logic [15:0] d);
      logic [7:0] rx;
      logic       n;
      u_host.start();
      u_host.byte_io({ADDR, 1'b0}, 1'b1, rx, n);
      u_host.byte_io(p, 1'b1, rx, n);
      u_host.start();
      u_host.byte_io({ADDR, 1'b1}, 1'b1, rx, n);
      u_host.byte_io(8'hff, 1'b0, d[7:0], n);
      u_host.byte_io(8'hff, 1'b1, d[15:8], n);
      u_host.stop();
   endtask : rd_word

   task automatic set_v(input logic [15:0] v);
      @(negedge clock);
      cell_voltage = v;
      @(negedge clock);
   endtask : set_v

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_values();
      logic [15:0] d;
      chk("nominal port", 16'h0bb8, nominal_capacity);
      rd_word(8'h18, d);
      chk("nominal read", 16'h0bb8, d);
      rd_word(8'h3a, d);
      chk("threshold read", 16'ha561, d);
   endtask : t_reset_values

   task automatic t_write_read();
      logic [15:0] d;
      logic [7:0]  rx;
      logic        n;
      wr_word(8'h18, 16'h1234);
      chk("nominal port", 16'h1234, nominal_capacity);
      rd_word(8'h18, d);
      chk("nominal read", 16'h1234, d);
      wr_word(8'h20, 16'h5555);
      rd_word(8'h20, d);
      chk("unmapped read", 16'h0000, d);
      // Foreign address must be left unanswered
      u_host.start();
      u_host.byte_io({ADDR + 7'h01, 1'b0}, 1'b1, rx, n);
      u_host.stop();
      chk("foreign nack", 16'h0001, {15'h0000, n});
   endtask : t_write_read

   task automatic t_formats();
      chk("whole percent", 16'h0032, {8'h00, whole_percent});
      chk("whole degrees", 16'h00e9, {8'h00, whole_degrees});
      chk("rep capacity", 16'h1770, reported_capacity);
      chk("sda drive value", 16'h0000, {15'h0000, sda_drv});
      @(negedge clock);
      temperature = 16'h1980;
      #1;
      chk("whole degrees", 16'h0019, {8'h00, whole_degrees});
   endtask : t_formats

   task automatic t_empty_default();
      set_v(16'd42241);
      chk("empty above", 16'h0000, {15'h0000, empty_detected});
      set_v(16'd42240);
      chk("empty at target", 16'h0001, {15'h0000, empty_detected});
      chk("rep pct empty", 16'h0000, reported_percent);
      chk("rep cap empty", 16'h0000, reported_capacity);
      set_v(16'd49664);
      chk("empty at recovery", 16'h0001, {15'h0000, empty_detected});
      set_v(16'd49665);
      chk("empty recovered", 16'h0000, {15'h0000, empty_detected});
      chk("rep pct back", 16'h3280, reported_percent);
      set_v(16'd42240);
      chk("empty rearmed", 16'h0001, {15'h0000, empty_detected});
      set_v(16'hffff);
   endtask : t_empty_default

   task automatic t_empty_rewrite();
      wr_word(8'h3a, 16'h8050);
      set_v(16'd32769);
      chk("empty 2.56 above", 16'h0000, {15'h0000, empty_detected});
      set_v(16'd32768);
      chk("empty 2.56", 16'h0001, {15'h0000, empty_detected});
      set_v(16'd40960);
      chk("recovery 3.2 at", 16'h0001, {15'h0000, empty_detected});
      set_v(16'd40961);
      chk("recovery 3.2", 16'h0000, {15'h0000, empty_detected});
      // Both fields at full scale
      wr_word(8'h3a, 16'hffff);
      set_v(16'd65409);
      chk("empty 5.11 above", 16'h0000, {15'h0000, empty_detected});
      set_v(16'd65408);
      chk("empty 5.11", 16'h0001, {15'h0000, empty_detected});
      set_v(16'hffff);
      chk("recovery 5.08", 16'h0000, {15'h0000, empty_detected});
   endtask : t_empty_rewrite

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      err_total = 0;
      checked = 0;
      cycles = 0;
      srst = 1'b1;
      cell_voltage = 16'hffff;
      raw_percent = 16'h3280;
      raw_capacity = 16'h1770;
      temperature = 16'he980;
      repeat (10) @(negedge clock);
      srst = 1'b0;
      repeat (4) @(negedge clock);
      t_reset_values();
      t_formats();
      t_write_read();
      t_empty_default();
      t_empty_rewrite();
      report_and_stop();
   end
endmodule : gauge_register_bank_tb_top
